// file: reload_timer_pwm_capture.sv
// two reload timers with pwm and capture behind an axi4-lite slave
// assumes one 50 MHz clock, synchronous reset and asynchronous pins
`timescale 1ns/1ps

// How it works
// - two timers, sixteen-bit counters with reload
// - prescaler divides by one to 128
// - pin counts, gates or captures; slow input
// - compare value formed from two pwm bytes
// - counter match changes the pwm output
// - polarity bit sets the pwm output level
// - capture stores count into pwm bytes
// - mode top bit joins control one field
// - two bits select interrupt raising events
// - flag shows interrupt came from capture
// - programmable deadband on output and complement in dual pwm mode
// - each timer drives pin and interrupt
module reload_timer_pwm_capture (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [reload_timer_pkg::AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [reload_timer_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi read
  input wire logic arvalid,
  output logic arready,
  input wire logic [reload_timer_pkg::AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [reload_timer_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  // timer pins
  input wire logic [reload_timer_pkg::NUM_TIMERS-1:0] timer_in,
  output logic [reload_timer_pkg::NUM_TIMERS-1:0] timer_out,
  output logic [reload_timer_pkg::NUM_TIMERS-1:0] timer_out_n,
  // interrupt
  output logic irq
);
  import reload_timer_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic [AXI_AW-1:0] awaddr;
    logic w_ok;
    logic [AXI_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic [NUM_TIMERS-1:0][7:0] stage;
    logic [NUM_TIMERS-1:0][15:0] reload;
    logic [NUM_TIMERS-1:0][15:0] compare;
    logic [NUM_TIMERS-1:0][7:0] ctl0;
    logic [NUM_TIMERS-1:0][7:0] ctl1;
    logic [NUM_TIMERS-1:0] status;
    logic [NUM_TIMERS-1:0] mask;
    logic [NUM_TIMERS-1:0] load;
    logic [NUM_TIMERS-1:0][15:0] load_val;
    logic irq;
  } top_state_type;

  top_state_type s, n;
  timer_cfg_type cfg [NUM_TIMERS];
  timer_stat_type stat [NUM_TIMERS];
  addr_dec_type wdec, rdec;
  logic [NUM_TIMERS-1:0] set_bits, clr_bits;
  logic [7:0] wbyte, rbyte;

  // split a byte address into block, timer and offset
  function automatic addr_dec_type decode(input logic [AXI_AW-1:0] a);
    addr_dec_type d;
    logic [13:0] idx;
    d = '0;
    idx = a[15:2];
    if (idx[13:4] == IDX_T0_BASE[13:4]) begin
      d.hit = 1'b1;
      d.timer = 1'b1;
      d.sel = idx[3];
      d.ofs = idx[2:0];
    end else if (idx == IDX_IRQ_STATUS) begin
      d.hit = 1'b1;
      d.status = 1'b1;
    end else if (idx == IDX_IRQ_MASK) begin
      d.hit = 1'b1;
      d.mask = 1'b1;
    end
    return d;
  endfunction : decode

  // settings handed to each timer
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      cfg[i].enable = s.ctl1[i][CTL1_ENABLE_BIT];
      cfg[i].polarity = s.ctl1[i][CTL1_POL_BIT];
      cfg[i].presc = s.ctl1[i][CTL1_PRESC_LSB +: 3];
      cfg[i].mode = {s.ctl0[i][CTL0_MODE_TOP_BIT],
        s.ctl1[i][CTL1_MODE_LSB +: 3]};
      cfg[i].ies = s.ctl0[i][CTL0_IES_LSB +: 2];
      cfg[i].dead = s.ctl0[i][CTL0_DEAD_LSB +: 3];
      cfg[i].reload = s.reload[i];
      cfg[i].compare = s.compare[i];
    end
  end

  // identical timer instances
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_timer
      timer_channel u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg[g]),
        .load_strobe(s.load[g]),
        .load_value(s.load_val[g]),
        .pin_in(timer_in[g]),
        .stat(stat[g])
      );
    end
  endgenerate

  // handshake readiness: one write and one read at a time
  assign awready = !s.aw_ok && !s.bvalid;
  assign wready = !s.w_ok && !s.bvalid;
  assign arready = !s.rvalid;

  // read data selection
  always_comb begin
    rdec = decode(araddr);
    rbyte = RST_BYTE;
    if (rdec.status) begin
      rbyte = {6'h00, s.status};
    end else if (rdec.mask) begin
      rbyte = {6'h00, s.mask};
    end else if (rdec.timer) begin
      case (rdec.ofs)
        OFS_COUNT_HIGH: rbyte = stat[rdec.sel].count[15:8];
        OFS_COUNT_LOW: rbyte = stat[rdec.sel].count[7:0];
        OFS_RELOAD_HIGH: rbyte = s.reload[rdec.sel][15:8];
        OFS_RELOAD_LOW: rbyte = s.reload[rdec.sel][7:0];
        OFS_PWM_HIGH: rbyte = s.compare[rdec.sel][15:8];
        OFS_PWM_LOW: rbyte = s.compare[rdec.sel][7:0];
        OFS_CTL0: rbyte = s.ctl0[rdec.sel];
        OFS_CTL1: rbyte = s.ctl1[rdec.sel];
        default: rbyte = RST_BYTE;
      endcase
    end
  end

  // next state: bus slave, register file and interrupt
  always_comb begin
    n = s;
    n.load = '0;
    clr_bits = '0;
    set_bits = '0;
    wdec = decode(s.awaddr);
    wbyte = s.wdata[7:0];
    // accept address and data in either order
    if (awvalid && awready) begin
      n.aw_ok = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_ok = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready) n.bvalid = 1'b0;
    // perform the write once both halves are in
    if (s.aw_ok && s.w_ok) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wdec.hit ? RESP_OKAY : RESP_SLVERR;
      if (wdec.hit && s.wstrb[0]) begin
        if (wdec.status) begin
          clr_bits = s.wdata[NUM_TIMERS-1:0];
        end else if (wdec.mask) begin
          n.mask = s.wdata[NUM_TIMERS-1:0];
        end else begin
          case (wdec.ofs)
            OFS_COUNT_HIGH: n.stage[wdec.sel] = wbyte;
            OFS_COUNT_LOW: begin
              n.load[wdec.sel] = 1'b1;
              n.load_val[wdec.sel] = {s.stage[wdec.sel], wbyte};
            end
            OFS_RELOAD_HIGH: n.reload[wdec.sel][15:8] = wbyte;
            OFS_RELOAD_LOW: n.reload[wdec.sel][7:0] = wbyte;
            OFS_PWM_HIGH: n.compare[wdec.sel][15:8] = wbyte;
            OFS_PWM_LOW: n.compare[wdec.sel][7:0] = wbyte;
            OFS_CTL0: begin
              n.ctl0[wdec.sel] = wbyte;
              n.ctl0[wdec.sel][CTL0_RSVD_BIT] = 1'b0;
              n.ctl0[wdec.sel][CTL0_CAP_FLAG_BIT] =
                s.ctl0[wdec.sel][CTL0_CAP_FLAG_BIT];
            end
            OFS_CTL1: n.ctl1[wdec.sel] = wbyte;
            default: n.ctl1 = s.ctl1;
          endcase
        end
      end
    end
    // hardware updates win over software in the same cycle
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (stat[i].oneshot_done) n.ctl1[i][CTL1_ENABLE_BIT] = 1'b0;
      if (stat[i].cap_valid) n.compare[i] = stat[i].cap_value;
      if (stat[i].irq_event) begin
        set_bits[i] = 1'b1;
        n.ctl0[i][CTL0_CAP_FLAG_BIT] = stat[i].irq_from_capture;
      end
    end
    // sticky status, set beats write-one-to-clear
    n.status = (s.status & ~clr_bits) | set_bits;
    n.irq = |(n.status & n.mask);
    // read answer
    if (s.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp = rdec.hit ? RESP_OKAY : RESP_SLVERR;
      n.rdata = {24'h000000, rbyte};
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end

  // outputs from state
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign irq = s.irq;
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      timer_out[i] = stat[i].out;
      timer_out_n[i] = stat[i].out_n;
    end
  end

  a_capture_store: assert property (@(posedge aclk) disable iff (!aresetn)
    stat[0].cap_valid |=> s.compare[0] == $past(stat[0].cap_value))
    else $error("capture value not stored in pwm bytes");
  a_capture_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    stat[1].irq_event |=>
    s.ctl0[1][CTL0_CAP_FLAG_BIT] == $past(stat[1].irq_from_capture))
    else $error("capture flag does not follow last interrupt");
  a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    (stat[0].irq_event && s.mask[0] && !(s.aw_ok && s.w_ok && wdec.mask))
    |=> irq ##0 s.status[0])
    else $error("unmasked event did not raise interrupt");
  a_status_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.status[1] && !(s.aw_ok && s.w_ok && wdec.status)) |=> s.status[1])
    else $error("status bit lost without clear");
  a_mode_top: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s.ctl0[0][CTL0_MODE_TOP_BIT]) |-> cfg[0].mode[3])
    else $error("mode top bit not most significant");
  a_oneshot_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    stat[0].oneshot_done |=> !s.ctl1[0][CTL1_ENABLE_BIT])
    else $error("one-shot timer still enabled");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.aw_ok && s.w_ok) |=> bvalid ##0 (bresp == RESP_OKAY) ==
    $past(wdec.hit))
    else $error("write answer missing or wrong");

endmodule : reload_timer_pwm_capture

// file: reload_timer_pkg.sv
// constants, field positions and carrier types of the reload timer block
// assumes a 50 MHz aclk and an AXI4-Lite master with 32-bit data
package reload_timer_pkg;

  // bus widths and timer count
  localparam int AXI_AW = 16;
  localparam int AXI_DW = 32;
  localparam int NUM_TIMERS = 2;

  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_T0_BASE = 14'h0F00;
  localparam logic [13:0] IDX_T0_PWM_LOW = 14'h0F05;
  localparam logic [13:0] IDX_T0_CTL0 = 14'h0F06;
  localparam logic [13:0] IDX_T1_BASE = 14'h0F08;
  localparam logic [13:0] IDX_T1_PWM_LOW = 14'h0F0D;
  localparam logic [13:0] IDX_T1_CTL0 = 14'h0F0E;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h0F10;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0F11;

  // offsets inside one timer block
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h0;
  localparam logic [2:0] OFS_COUNT_LOW = 3'h1;
  localparam logic [2:0] OFS_RELOAD_HIGH = 3'h2;
  localparam logic [2:0] OFS_RELOAD_LOW = 3'h3;
  localparam logic [2:0] OFS_PWM_HIGH = 3'h4;
  localparam logic [2:0] OFS_PWM_LOW = 3'h5;
  localparam logic [2:0] OFS_CTL0 = 3'h6;
  localparam logic [2:0] OFS_CTL1 = 3'h7;

  // field positions of control zero and control one
  localparam int CTL0_MODE_TOP_BIT = 7;
  localparam int CTL0_IES_LSB = 5;
  localparam int CTL0_RSVD_BIT = 4;
  localparam int CTL0_DEAD_LSB = 1;
  localparam int CTL0_CAP_FLAG_BIT = 0;
  localparam int CTL1_ENABLE_BIT = 7;
  localparam int CTL1_POL_BIT = 6;
  localparam int CTL1_PRESC_LSB = 3;
  localparam int CTL1_MODE_LSB = 0;

  // reset values and counter start
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_START = 16'h0001;

  // operating modes
  localparam logic [3:0] MODE_ONE_SHOT = 4'h0;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
  localparam logic [3:0] MODE_COUNTER = 4'h2;
  localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_COMPARE = 4'h5;
  localparam logic [3:0] MODE_GATED = 4'h6;
  localparam logic [3:0] MODE_CAPTURE_COMPARE = 4'h7;
  localparam logic [3:0] MODE_PWM_DUAL = 4'h8;

  // interrupt event choices
  localparam logic [1:0] IES_CAPTURE = 2'h2;
  localparam logic [1:0] IES_RELOAD_MATCH = 2'h3;

  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic polarity;
    logic [2:0] presc;
    logic [3:0] mode;
    logic [1:0] ies;
    logic [2:0] dead;
    logic [15:0] reload;
    logic [15:0] compare;
  } timer_cfg_type;

  typedef struct packed {
    logic [15:0] count;
    logic cap_valid;
    logic [15:0] cap_value;
    logic irq_event;
    logic irq_from_capture;
    logic oneshot_done;
    logic out;
    logic out_n;
  } timer_stat_type;

  typedef struct packed {
    logic hit;
    logic timer;
    logic status;
    logic mask;
    logic sel;
    logic [2:0] ofs;
  } addr_dec_type;

endpackage : reload_timer_pkg

// file: timer_channel.sv
// one 16-bit reload timer: prescaler, counter, pwm and capture
// assumes settings from the register file, pin input is asynchronous
`timescale 1ns/1ps

module timer_channel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and software count load
  input wire reload_timer_pkg::timer_cfg_type cfg,
  input wire logic load_strobe,
  input wire logic [15:0] load_value,
  // pin and results
  input wire logic pin_in,
  output reload_timer_pkg::timer_stat_type stat
);
  import reload_timer_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [6:0] presc;
    logic [15:0] count;
    logic raw;
    logic [2:0] dead;
    logic out;
    logic out_n;
    logic cap_valid;
    logic [15:0] cap_value;
    logic irq_event;
    logic irq_from_capture;
    logic oneshot_done;
  } chan_state_type;

  chan_state_type s, n;
  logic act_edge, active_lvl, tick, advance, cap, match, wrap;

  // last prescaler count for a divide by two to the power ps
  function automatic logic [6:0] presc_last(input logic [2:0] ps);
    logic [7:0] span;
    span = 8'h01 << ps;
    return 7'(span - 8'h01);
  endfunction : presc_last

  // next state of the whole channel
  always_comb begin
    n = s;
    act_edge = 1'b0;
    tick = 1'b0;
    n.sync = {s.sync[1:0], pin_in};
    n.cap_valid = 1'b0;
    n.irq_event = 1'b0;
    n.oneshot_done = 1'b0;
    if (s.sync[2] == s.sync[1] && s.sync[2] != s.level) begin
      n.level = s.sync[2];
      act_edge = (s.sync[2] != cfg.polarity);
    end
    active_lvl = (s.level != cfg.polarity);
    if (cfg.enable) begin
      // at or past the limit so a smaller ratio takes effect at once
      tick = (s.presc >= presc_last(cfg.presc));
      n.presc = tick ? 7'h00 : s.presc + 7'h01;
    end else begin
      n.presc = 7'h00;
    end
    case (cfg.mode)
      MODE_COUNTER: advance = act_edge;
      MODE_GATED: advance = tick && active_lvl;
      default: advance = tick;
    endcase
    advance = advance && cfg.enable;
    cap = cfg.enable && act_edge && (cfg.mode == MODE_CAPTURE ||
      cfg.mode == MODE_CAPTURE_COMPARE);
    match = advance && (s.count == cfg.compare);
    wrap = advance && (s.count == cfg.reload);
    // counter with reload
    if (load_strobe) begin
      n.count = load_value;
    end else if (wrap || (cap && cfg.mode == MODE_CAPTURE_COMPARE)) begin
      n.count = COUNT_START;
    end else if (advance) begin
      n.count = s.count + 16'h0001;
    end
    n.oneshot_done = wrap && (cfg.mode == MODE_ONE_SHOT);
    // raw output level
    case (cfg.mode)
      MODE_PWM_SINGLE, MODE_PWM_DUAL: begin
        if (wrap) n.raw = cfg.polarity;
        else if (match) n.raw = ~cfg.polarity;
      end
      MODE_COMPARE: begin
        if (match) n.raw = ~s.raw;
      end
      default: begin
        if (wrap) n.raw = ~s.raw;
      end
    endcase
    // deadband: in dual pwm mode both pins idle while the delay runs
    if (n.raw != s.raw) n.dead = cfg.dead;
    else if (s.dead != 3'h0) n.dead = s.dead - 3'h1;
    if (cfg.mode == MODE_PWM_DUAL && n.dead != 3'h0) begin
      n.out = cfg.polarity;
      n.out_n = cfg.polarity;
    end else begin
      n.out = n.raw;
      n.out_n = ~n.raw;
    end
    if (cap) begin
      n.cap_valid = 1'b1;
      n.cap_value = s.count;
    end
    // interrupt event selection
    case (cfg.ies)
      IES_CAPTURE: n.irq_event = cap;
      IES_RELOAD_MATCH: n.irq_event = wrap || match;
      default: n.irq_event = cap || wrap || match;
    endcase
    n.irq_from_capture = cap;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end

  // results from flip-flops
  assign stat = '{count: s.count, cap_valid: s.cap_valid,
    cap_value: s.cap_value, irq_event: s.irq_event,
    irq_from_capture: s.irq_from_capture, oneshot_done: s.oneshot_done,
    out: s.out, out_n: s.out_n};

  a_sync_agree: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s.level) |-> $past(s.sync[2]) == $past(s.sync[1]))
    else $error("level changed without two agreeing stages");
  a_presc_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    $stable(cfg.presc) |-> s.presc <= presc_last(cfg.presc))
    else $error("prescaler passed its limit");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (advance && !wrap && !load_strobe && !cap) |=>
    s.count == $past(s.count) + 16'h0001)
    else $error("counter did not step by one");
  a_reload_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (wrap && !load_strobe) |=> s.count == COUNT_START && s.irq_event ==
    ($past(cfg.ies) != IES_CAPTURE || $past(cap)))
    else $error("reload did not restart or signal");
  a_pwm_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (match && !wrap && cfg.mode == MODE_PWM_SINGLE) |=>
    s.raw == ~$past(cfg.polarity))
    else $error("pwm level wrong after match");
  a_irq_select: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.ies == IES_CAPTURE && !cap) |=> !s.irq_event)
    else $error("non-capture event raised in capture-only");
  a_deadband_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    ($stable(cfg) && cfg.mode == MODE_PWM_DUAL && s.dead != 3'h0) |->
    s.out == cfg.polarity && s.out_n == cfg.polarity)
    else $error("output driven inside deadband");

endmodule : timer_channel

// file: timer_pin_model.sv
// drives the external timer input pins as the far side would
// assumes the bench asks for levels; changes are spaced five clocks apart
`timescale 1ns/1ps

module timer_pin_model (
  // clock
  input wire logic aclk,
  // wanted levels from the bench
  input wire logic [1:0] want,
  // pins towards the timers
  output logic [1:0] pin
);
  logic [1:0] lvl = 2'h0;
  logic [2:0] hold [2] = '{3'h0, 3'h0};

  assign pin = lvl;

  // follow the wanted level, never toggling faster than a fifth of aclk
  always @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (hold[i] != 3'h0) begin
        hold[i] <= hold[i] - 3'h1;
      end else if (lvl[i] != want[i]) begin
        lvl[i] <= want[i];
        hold[i] <= 3'h4;
      end
    end
  end
endmodule : timer_pin_model

// file: tb_top.sv
// self-checking bench for the two reload timers over axi4-lite
// assumes the pin model on timer_in and a 50 MHz aclk
`timescale 1ns/1ps

module tb_top;
  import reload_timer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [1:0] bresp, rresp, timer_in, timer_out, timer_out_n;
  logic [1:0] want = 2'h0;
  logic [31:0] d, e;
  int n_fail = 0, checked = 0, cyc;

  // clock
  always #10 aclk = ~aclk;

  reload_timer_pwm_capture reload_timer_pwm_capture_i (.aclk, .aresetn,
    .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .timer_in, .timer_out, .timer_out_n,
    .irq);

  timer_pin_model timer_pin_model_i (.aclk, .want, .pin(timer_in));

  // comparisons
  task automatic cmp_data(input string s, input logic [31:0] x,
                          input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask : cmp_data

  task automatic cmp_count(input string s, input int x, input int g);
    checked++;
    if (g != x) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", s, x, g);
    end
  endtask : cmp_count

  // design output levels looked at mid-cycle: what 0 irq, 1 the pins
  task automatic cmp_pins(input string s, input int what,
                          input logic [3:0] x);
    logic [3:0] g;
    @(negedge aclk);
    g = (what == 0) ? {3'h0, irq} : {timer_out, timer_out_n};
    cmp_data(s, {28'h0, x}, {28'h0, g});
    @(posedge aclk);
  endtask : cmp_pins

  // one axi write, both halves offered together
  task automatic wr(input logic [13:0] idx, input logic [7:0] v,
                    input logic [1:0] x = RESP_OKAY);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    cmp_data("bresp", {30'h0, x}, {30'h0, r});
  endtask : wr

  // one axi read
  task automatic rd(input logic [13:0] idx, input logic [1:0] x,
                    output logic [31:0] v);
    logic a_t, r_t;
    logic [1:0] r;
    r_t = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      a_t = arvalid && arready;
      r_t = rvalid;
      r = rresp;
      v = rdata;
      @(posedge aclk);
      if (a_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    cmp_data("rresp", {30'h0, x}, {30'h0, r});
  endtask : rd

  task automatic chk(input logic [13:0] idx, input logic [7:0] x);
    logic [31:0] v;
    rd(idx, RESP_OKAY, v);
    cmp_data("register", {24'h0, x}, v);
  endtask : chk

  // cycles between the second and third rise of an output
  task automatic period(input int i, output int c);
    logic p;
    int n;
    n = 0;
    c = 0;
    p = timer_out[i];
    while (n < 3) begin
      @(negedge aclk);
      if (timer_out[i] && !p) n++;
      if (n == 2) c++;
      p = timer_out[i];
    end
    @(posedge aclk);
  endtask : period

  // over two periods: kind 0 counts high cycles, kind 1 both-low cycles
  task automatic level_count(input int i, input int kind, output int c);
    c = 0;
    repeat (48) @(negedge aclk);
    repeat (32) begin
      @(negedge aclk);
      if (kind == 0 && timer_out[i] === 1'b1) c++;
      if (kind == 1 && timer_out[i] === 1'b0 && timer_out_n[i] === 1'b0) c++;
    end
    @(posedge aclk);
  endtask : level_count

  // verdict
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_pins("pins after reset", 1, 4'h3);
    // reset values and an unmapped place
    chk(IDX_T0_PWM_LOW, 8'h00);
    chk(IDX_T0_CTL0, 8'h00);
    chk(IDX_T1_PWM_LOW, 8'h00);
    chk(IDX_T1_CTL0, 8'h00);
    rd(14'h0F20, RESP_SLVERR, d);
    cmp_data("unmapped data", 32'h0, d);
    wr(14'h0F20, 8'h55, RESP_SLVERR);
    // control zero fields; reserved and capture flag read zero
    wr(IDX_T0_CTL0, 8'hFF);
    chk(IDX_T0_CTL0, 8'hEE);
    wr(IDX_T0_CTL0, 8'h00);
    // timer one block sits eight above timer zero
    wr(IDX_T1_PWM_LOW, 8'h5A);
    wr(IDX_T0_PWM_LOW, 8'hA5);
    chk(IDX_T1_PWM_LOW, 8'h5A);
    chk(IDX_T0_PWM_LOW, 8'hA5);
    // timer one pwm: reload 16, compare 8, prescaler boundaries
    wr(IDX_T1_BASE + 14'h2, 8'h00);
    wr(IDX_T1_BASE + 14'h3, 8'h10);
    wr(IDX_T1_BASE + 14'h4, 8'h00);
    wr(IDX_T1_PWM_LOW, 8'h08);
    wr(IDX_T1_CTL0, 8'h60);
    wr(IDX_IRQ_MASK, 8'h02);
    for (int k = 0; k < 8; k++) begin
      if (k == 0 || k == 1 || k == 7) begin
        wr(IDX_T1_BASE + 14'h7, 8'h83 | 8'(k << 3));
        period(1, cyc);
        cmp_count("pwm period", 16 << k, cyc);
      end
    end
    cmp_pins("complement", 1, 4'h9);
    // polarity with compare 4: high 12 of 16 or 4 of 16
    wr(IDX_T1_PWM_LOW, 8'h04);
    wr(IDX_T1_BASE + 14'h7, 8'h83);
    level_count(1, 0, cyc);
    cmp_count("high cycles pol0", 24, cyc);
    wr(IDX_T1_BASE + 14'h7, 8'hC3);
    level_count(1, 0, cyc);
    cmp_count("high cycles pol1", 8, cyc);
    // reload and match raised the interrupt; flag shows no capture
    chk(IDX_IRQ_STATUS, 8'h02);
    cmp_pins("irq", 0, 4'h1);
    chk(IDX_T1_CTL0, 8'h60);
    wr(IDX_T1_BASE + 14'h7, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h02);
    chk(IDX_IRQ_STATUS, 8'h00);
    cmp_pins("irq cleared", 0, 4'h0);
    // dual pwm via mode top bit, deadband three clocks per change
    wr(IDX_T1_CTL0, 8'h86);
    wr(IDX_T1_BASE + 14'h7, 8'h80);
    level_count(1, 1, cyc);
    cmp_count("deadband cycles", 12, cyc);
    wr(IDX_T1_BASE + 14'h7, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h02);
    // timer zero capture on a rising pin edge
    wr(IDX_T0_BASE + 14'h2, 8'hFF);
    wr(IDX_T0_BASE + 14'h3, 8'hFF);
    wr(IDX_T0_CTL0, 8'h40);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_T0_BASE + 14'h7, 8'h84);
    repeat (20) @(posedge aclk);
    want <= 2'h1;
    repeat (12) @(posedge aclk);
    chk(IDX_IRQ_STATUS, 8'h01);
    cmp_pins("irq capture", 0, 4'h1);
    chk(IDX_T0_CTL0, 8'h41);
    rd(IDX_T0_BASE + 14'h4, RESP_OKAY, d);
    rd(IDX_T0_PWM_LOW, RESP_OKAY, e);
    cmp_data("capture nonzero", 32'h1, {31'h0, (d | e) != 32'h0});
    // masked: status stays but the line drops, then clear
    wr(IDX_IRQ_MASK, 8'h00);
    cmp_pins("irq masked", 0, 4'h0);
    wr(IDX_IRQ_STATUS, 8'h01);
    chk(IDX_IRQ_STATUS, 8'h00);
    // counter mode on rising pin edges after a software load of zero
    wr(IDX_T0_BASE + 14'h7, 8'h00);
    wr(IDX_T0_BASE + 14'h0, 8'h00);
    wr(IDX_T0_BASE + 14'h1, 8'h00);
    wr(IDX_T0_BASE + 14'h7, 8'h82);
    want <= 2'h0;
    repeat (12) @(posedge aclk);
    want <= 2'h1;
    repeat (12) @(posedge aclk);
    chk(IDX_T0_BASE + 14'h1, 8'h01);
    // one-shot to reload four clears its own enable
    wr(IDX_T0_BASE + 14'h7, 8'h00);
    wr(IDX_T0_BASE + 14'h2, 8'h00);
    wr(IDX_T0_BASE + 14'h3, 8'h04);
    wr(IDX_T0_BASE + 14'h7, 8'h80);
    repeat (20) @(posedge aclk);
    chk(IDX_T0_BASE + 14'h7, 8'h00);
    finish_test();
  end
endmodule : tb_top
